/* smd_consts.svh */
`ifndef SMD_CONSTS_SVH
`define SMD_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SMD_ADDR_W        8
`define SMD_OFF_CTRL      8'h30
`define SMD_OFF_STATUS    8'h34
`define SMD_OFF_TAIL      8'h38
`define SMD_OFF_LEN       8'h3C
`define SMD_OFF_IRQ_STAT  8'h40
`define SMD_OFF_IRQ_MASK  8'h44

// ----------------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------------
`define SMD_CTRL_RUN      0
`define SMD_CTRL_LENCHK   1
`define SMD_ST_HALTED     0
`define SMD_ST_IDLE       1
`define SMD_ST_RSVD       2
`define SMD_ST_DESC       3
`define SMD_ST_INTERR     4
`define SMD_IRQ_HALT      0
`define SMD_IRQ_IDLE      1
`define SMD_IRQ_ERR       2
`define SMD_IRQ_W         3
`define SMD_LEN_W         26

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SMD_RST_WORD      32'h0000_0000
`define SMD_RST_LEN       26'h000_0000
`define SMD_RST_IRQ       3'h0
`define SMD_RST_DESC_OPT  1'h1

`endif

/* smd_pkg.sv */
package smd_pkg;

  // channel run/stop sequencing
  typedef enum logic [1:0] {
    CH_HALTED   = 2'b00,
    CH_RUNNING  = 2'b01,
    CH_STOPPING = 2'b10
  } smd_chan_state_t;

endpackage

/* smd_status.sv */
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
// Function
// - the channel status word is readable at byte offset 34h.
// - status bit 0 reads 1 after reset and while halted, 0 while running.
// - halted sets once run is 0 and data (and descriptor) work has stopped.
// - halt follows a run clear after a variable lag; software polls for it.
// - a tail pointer write while halted in descriptor mode starts nothing.
// - a length write while halted in direct mode starts nothing.
// - descriptor mode idle reads 1 once the tail is reached, else 0.
// - a tail pointer write in descriptor mode restarts work from idle.
// - direct mode idle reads 1 once the current transfer completes.
// - idle is 0 while halted, and 0 before the first direct transfer.
// - status bit 2 is reserved, reads zero and ignores writes.
// - a fetched descriptor with buffer length 0 sets the error flag.
// - in descriptor mode, a received length differing from the packet length sets the flag.
// - direct mode write errors or oversize packets set the error flag.
// - an internal error clears run and halts after the engine stops.
`include "smd_consts.svh"

module smd_status
  import smd_pkg::*;
#(
  parameter bit DESC_ENGINE_BUILD_OPTION = `SMD_RST_DESC_OPT
) (
  input  wire logic                   pclk,           // register clock
  input  wire logic                   presetn,        // async reset, low
  input  wire logic                   psel,           // apb select
  input  wire logic                   penable,        // apb access phase
  input  wire logic                   pwrite,         // apb direction
  input  wire logic [`SMD_ADDR_W-1:0] paddr,          // apb byte address
  input  wire logic [31:0]            pwdata,         // apb write data
  output logic [31:0]                 prdata,         // apb read data
  output logic                        pready,         // apb ready
  output logic                        pslverr,        // apb error
  input  wire logic                   dm_busy,        // data mover active
  input  wire logic                   desc_busy,      // descriptor ops active
  input  wire logic                   desc_at_tail,   // tail reached, all done
  input  wire logic                   xfer_done,      // direct xfer complete
  input  wire logic                   zero_len_desc,  // descriptor length 0
  input  wire logic                   rxlen_valid,    // status length strobe
  input  wire logic [`SMD_LEN_W-1:0]  rxlen_value,    // received_length_field
  input  wire logic [`SMD_LEN_W-1:0]  pkt_len,        // stream_input_port len
  input  wire logic                   wr_err,         // memory write error
  input  wire logic                   pkt_too_long,   // packet over length
  output logic                        run_control_bit,// run to engine
  output logic                        tail_start,     // restart pulse
  output logic [31:0]                 tail_descriptor_pointer, // tail value
  output logic                        len_start,      // direct start pulse
  output logic [`SMD_LEN_W-1:0]       xfer_len,       // transfer length
  output logic                        irq             // level interrupt
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  smd_chan_state_t         chan_state_reg;
  smd_chan_state_t         chan_state_next;
  logic                    run_reg;
  logic                    lenchk_reg;
  logic                    idle_reg;
  logic                    idle_q_reg;
  logic                    int_err_reg;
  logic [31:0]             tail_reg;
  logic [`SMD_LEN_W-1:0]   len_reg;
  logic                    tail_start_reg;
  logic                    len_start_reg;
  logic [`SMD_IRQ_W-1:0]   irq_stat_reg;
  logic [`SMD_IRQ_W-1:0]   irq_mask_reg;
  logic [`SMD_IRQ_W-1:0]   irq_evt;
  logic                    irq_reg;
  logic [31:0]             prdata_reg;
  logic                    pready_reg;
  logic                    pslverr_reg;
  logic                    apb_setup;
  logic                    apb_wr;
  logic                    addr_ok;
  logic                    halted;
  logic                    running;
  logic                    engine_stopped;
  logic                    err_evt;
  logic                    len_mismatch;
  logic [31:0]             status_word;
  logic [31:0]             rd_word;

  // ----------------------------------------------------------------------
  // apb slave, zero wait, ready from a flop
  // ----------------------------------------------------------------------
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pready_reg & pwrite;

  always_comb begin
    addr_ok = 1'b1;
    rd_word = `SMD_RST_WORD;
    unique case (paddr)
      `SMD_OFF_CTRL: begin
        rd_word[`SMD_CTRL_RUN]    = run_reg;
        rd_word[`SMD_CTRL_LENCHK] = lenchk_reg;
      end
      `SMD_OFF_STATUS:   rd_word = status_word;
      `SMD_OFF_TAIL:     rd_word = tail_reg;
      `SMD_OFF_LEN:      rd_word[`SMD_LEN_W-1:0] = len_reg;
      `SMD_OFF_IRQ_STAT: rd_word[`SMD_IRQ_W-1:0] = irq_stat_reg;
      `SMD_OFF_IRQ_MASK: rd_word[`SMD_IRQ_W-1:0] = irq_mask_reg;
      default:           addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= `SMD_RST_WORD;
    end else begin
      pready_reg  <= apb_setup;
      pslverr_reg <= apb_setup & ~addr_ok;
      if (apb_setup && !pwrite) begin
        prdata_reg <= rd_word;
      end
    end
  end

  // ----------------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------------
  assign halted  = (chan_state_reg == CH_HALTED);
  assign running = (chan_state_reg == CH_RUNNING);

  always_comb begin
    status_word                 = `SMD_RST_WORD;
    status_word[`SMD_ST_HALTED] = halted;
    status_word[`SMD_ST_IDLE]   = idle_reg;
    status_word[`SMD_ST_RSVD]   = 1'b0;
    status_word[`SMD_ST_DESC]   = DESC_ENGINE_BUILD_OPTION;
    status_word[`SMD_ST_INTERR] = int_err_reg;
  end

  // ----------------------------------------------------------------------
  // control register and run bit
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg    <= 1'b0;
      lenchk_reg <= 1'b0;
    end else begin
      if (err_evt) begin
        run_reg <= 1'b0;
      end else if (apb_wr && paddr == `SMD_OFF_CTRL) begin
        run_reg <= pwdata[`SMD_CTRL_RUN];
      end
      if (apb_wr && paddr == `SMD_OFF_CTRL) begin
        lenchk_reg <= pwdata[`SMD_CTRL_LENCHK];
      end
    end
  end

  // ----------------------------------------------------------------------
  // run/stop sequencing
  // ----------------------------------------------------------------------
  assign engine_stopped = ~dm_busy &
                          (~DESC_ENGINE_BUILD_OPTION | ~desc_busy);

  always_comb begin
    chan_state_next = chan_state_reg;
    unique case (chan_state_reg)
      CH_HALTED:
        if (run_reg) chan_state_next = CH_RUNNING;
      CH_RUNNING:
        if (!run_reg) chan_state_next = CH_STOPPING;
      CH_STOPPING:
        if (run_reg) chan_state_next = CH_RUNNING;
        else if (engine_stopped) chan_state_next = CH_HALTED;
      default:
        chan_state_next = CH_HALTED;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_state_reg <= CH_HALTED;
    end else begin
      chan_state_reg <= chan_state_next;
    end
  end

  // ----------------------------------------------------------------------
  // tail pointer and transfer length
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tail_reg       <= `SMD_RST_WORD;
      len_reg        <= `SMD_RST_LEN;
      tail_start_reg <= 1'b0;
      len_start_reg  <= 1'b0;
    end else begin
      if (apb_wr && paddr == `SMD_OFF_TAIL) begin
        tail_reg <= pwdata;
      end
      if (apb_wr && paddr == `SMD_OFF_LEN) begin
        len_reg <= pwdata[`SMD_LEN_W-1:0];
      end
      tail_start_reg <= apb_wr && paddr == `SMD_OFF_TAIL &&
                        DESC_ENGINE_BUILD_OPTION && running;
      len_start_reg  <= apb_wr && paddr == `SMD_OFF_LEN &&
                        !DESC_ENGINE_BUILD_OPTION && running;
    end
  end

  // ----------------------------------------------------------------------
  // idle flag
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_reg   <= 1'b0;
      idle_q_reg <= 1'b0;
    end else begin
      idle_q_reg <= idle_reg;
      if (!running) begin
        idle_reg <= 1'b0;
      end else if (DESC_ENGINE_BUILD_OPTION) begin
        idle_reg <= desc_at_tail & ~tail_start_reg;
      end else if (len_start_reg) begin
        idle_reg <= 1'b0;
      end else if (xfer_done) begin
        idle_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // internal error detection
  // ----------------------------------------------------------------------
  assign len_mismatch = lenchk_reg & rxlen_valid &
                        (rxlen_value != pkt_len);

  assign err_evt = DESC_ENGINE_BUILD_OPTION ?
                   (zero_len_desc | len_mismatch) :
                   (wr_err | pkt_too_long);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_err_reg <= 1'b0;
    end else if (err_evt) begin
      int_err_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt status, write one to clear, set wins
  // ----------------------------------------------------------------------
  assign irq_evt[`SMD_IRQ_HALT] = (chan_state_reg == CH_STOPPING) &
                                  (chan_state_next == CH_HALTED);
  assign irq_evt[`SMD_IRQ_IDLE] = idle_reg & ~idle_q_reg;
  assign irq_evt[`SMD_IRQ_ERR]  = err_evt & ~int_err_reg;

  genvar gi;
  generate
    for (gi = 0; gi < `SMD_IRQ_W; gi = gi + 1) begin : g_irq
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          irq_stat_reg[gi] <= 1'b0;
        end else if (irq_evt[gi]) begin
          irq_stat_reg[gi] <= 1'b1;
        end else if (apb_wr && paddr == `SMD_OFF_IRQ_STAT &&
                     pwdata[gi]) begin
          irq_stat_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= `SMD_RST_IRQ;
      irq_reg      <= 1'b0;
    end else begin
      if (apb_wr && paddr == `SMD_OFF_IRQ_MASK) begin
        irq_mask_reg <= pwdata[`SMD_IRQ_W-1:0];
      end
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign prdata                  = prdata_reg;
  assign pready                  = pready_reg;
  assign pslverr                 = pslverr_reg;
  assign run_control_bit         = run_reg;
  assign tail_start              = tail_start_reg;
  assign tail_descriptor_pointer = tail_reg;
  assign len_start               = len_start_reg;
  assign xfer_len                = len_reg;
  assign irq                     = irq_reg;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_status_read;
    @(posedge pclk) disable iff (!presetn)
    (apb_setup && !pwrite && paddr == `SMD_OFF_STATUS) |=>
      (prdata_reg[`SMD_ST_HALTED] == $past(halted) &&
       prdata_reg[`SMD_ST_INTERR] == $past(int_err_reg));
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read data wrong");

  property p_run_leaves_halt;
    @(posedge pclk) disable iff (!presetn)
    (halted && run_reg) |=> !halted;
  endproperty
  a_run_leaves_halt: assert property (p_run_leaves_halt)
    else $error("halted stayed set with run high");

  property p_halt_cause;
    @(posedge pclk) disable iff (!presetn)
    $rose(halted) |-> $past(!run_reg && engine_stopped);
  endproperty
  a_halt_cause: assert property (p_halt_cause)
    else $error("halted set without stop condition");

  property p_tail_halted;
    @(posedge pclk) disable iff (!presetn)
    (halted && apb_wr && paddr == `SMD_OFF_TAIL) |=> !tail_start_reg;
  endproperty
  a_tail_halted: assert property (p_tail_halted)
    else $error("tail write while halted started work");

  property p_len_halted;
    @(posedge pclk) disable iff (!presetn)
    (halted && apb_wr && paddr == `SMD_OFF_LEN) |=> !len_start_reg;
  endproperty
  a_len_halted: assert property (p_len_halted)
    else $error("length write while halted started work");

  property p_tail_restart;
    @(posedge pclk) disable iff (!presetn)
    (DESC_ENGINE_BUILD_OPTION && running &&
     apb_wr && paddr == `SMD_OFF_TAIL) |=> tail_start_reg ##1 !idle_reg;
  endproperty
  a_tail_restart: assert property (p_tail_restart)
    else $error("tail write did not restart");

  property p_direct_idle;
    @(posedge pclk) disable iff (!presetn)
    (!DESC_ENGINE_BUILD_OPTION && running && xfer_done &&
     !len_start_reg) |=> idle_reg;
  endproperty
  a_direct_idle: assert property (p_direct_idle)
    else $error("idle not set after direct transfer");

  property p_idle_halt;
    @(posedge pclk) disable iff (!presetn)
    halted |-> !idle_reg;
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("idle set while halted");

  property p_rsvd_zero;
    @(posedge pclk) disable iff (!presetn)
    (apb_setup && !pwrite && paddr == `SMD_OFF_STATUS) |=>
      (prdata_reg[`SMD_ST_RSVD] == 1'b0 &&
       prdata_reg[`SMD_ST_DESC] == DESC_ENGINE_BUILD_OPTION);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved or option bit wrong");

  property p_err_set;
    @(posedge pclk) disable iff (!presetn)
    err_evt |=> (int_err_reg && !run_reg);
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("error did not set flag and clear run");

  property p_err_sticky;
    @(posedge pclk) disable iff (!presetn)
    int_err_reg |=> int_err_reg [*4];
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("internal error flag cleared");

endmodule

/* smd_engine_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// behavioural descriptor engine and data mover
// ----------------------------------------------------------------------
module smd_engine_model (
  input  wire logic pclk,          // register clock
  input  wire logic presetn,       // async reset, low
  input  wire logic tail_start,    // restart pulse from block
  input  wire logic slow,          // long job when high
  output logic      dm_busy,       // data mover active
  output logic      desc_busy,     // descriptor ops active
  output logic      desc_at_tail,  // tail reached, queue empty
  output logic      xfer_done      // job complete pulse
);
  logic [7:0] cnt_reg;

  // job runs to its end even after run falls, so halt lags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg      <= 8'h00;
      dm_busy      <= 1'b0;
      desc_busy    <= 1'b0;
      desc_at_tail <= 1'b0;
      xfer_done    <= 1'b0;
    end else begin
      xfer_done <= 1'b0;
      if (tail_start) begin
        cnt_reg      <= slow ? 8'h14 : 8'h03;
        dm_busy      <= 1'b1;
        desc_busy    <= 1'b1;
        desc_at_tail <= 1'b0;
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end else if (dm_busy) begin
        dm_busy      <= 1'b0;
        desc_busy    <= 1'b0;
        desc_at_tail <= 1'b1;
        xfer_done    <= 1'b1;
      end
    end
  end
endmodule

/* tb_stream_to_memory_dma_status.sv */
`timescale 1ns/1ps
`include "smd_consts.svh"
module tb_stream_to_memory_dma_status;
  typedef struct {logic [31:0] exp; logic [31:0] msk;
                  logic err; logic dir;} smd_note_t;
  logic                  pclk, presetn, psel, penable, pwrite, pready;
  logic [`SMD_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata, prdata, tail_ptr;
  logic                  pslverr, dm_busy, desc_busy, desc_at_tail, xfer_done;
  logic                  zero_len_desc, rxlen_valid, wr_err, pkt_too_long;
  logic [`SMD_LEN_W-1:0] rxlen_value, pkt_len, xfer_len;
  logic                  run_bit, tail_start, len_start, irq, slow;
  logic [31:0]           d_prdata;
  logic                  d_pslverr, d_dm_busy, d_desc_busy, d_at_tail;
  logic                  d_xfer_done, d_run, d_tail_start, d_len_start;
  logic [`SMD_LEN_W-1:0] d_xfer_len;
  smd_note_t             notes[$];
  int                    failures, samples_checked, starts, cycles;
  int                    dstarts;

  smd_status #(.DESC_ENGINE_BUILD_OPTION(1'b1)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dm_busy(dm_busy),
    .desc_busy(desc_busy), .desc_at_tail(desc_at_tail),
    .xfer_done(xfer_done), .zero_len_desc(zero_len_desc),
    .rxlen_valid(rxlen_valid), .rxlen_value(rxlen_value),
    .pkt_len(pkt_len), .wr_err(wr_err), .pkt_too_long(pkt_too_long),
    .run_control_bit(run_bit), .tail_start(tail_start),
    .tail_descriptor_pointer(tail_ptr), .len_start(len_start),
    .xfer_len(xfer_len), .irq(irq));

  smd_engine_model u_eng (
    .pclk(pclk), .presetn(presetn), .tail_start(tail_start), .slow(slow),
    .dm_busy(dm_busy), .desc_busy(desc_busy),
    .desc_at_tail(desc_at_tail), .xfer_done(xfer_done));

  // direct build on the same register bus, its own engine
  smd_status #(.DESC_ENGINE_BUILD_OPTION(1'b0)) DUT_DIRECT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(d_prdata),
    .pready(), .pslverr(d_pslverr), .dm_busy(d_dm_busy),
    .desc_busy(d_desc_busy), .desc_at_tail(d_at_tail),
    .xfer_done(d_xfer_done), .zero_len_desc(zero_len_desc),
    .rxlen_valid(rxlen_valid), .rxlen_value(rxlen_value),
    .pkt_len(pkt_len), .wr_err(wr_err), .pkt_too_long(pkt_too_long),
    .run_control_bit(d_run), .tail_start(d_tail_start),
    .tail_descriptor_pointer(), .len_start(d_len_start),
    .xfer_len(d_xfer_len), .irq());

  smd_engine_model u_eng_d (
    .pclk(pclk), .presetn(presetn), .tail_start(d_len_start), .slow(slow),
    .dm_busy(d_dm_busy), .desc_busy(d_desc_busy),
    .desc_at_tail(d_at_tail), .xfer_done(d_xfer_done));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ----------------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task close_out();
    if (failures == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (tail_start === 1'b1 || len_start === 1'b1) starts++;
    if (d_tail_start === 1'b1 || d_len_start === 1'b1) dstarts++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end

  // read monitor takes the oldest note per completed read
  always @(posedge pclk) begin
    smd_note_t n;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (notes.size() == 0) begin
        failures++;
        $display("MISMATCH %0t read with no note", $time);
      end else begin
        n = notes.pop_front();
        if (n.msk != 32'h0000_0000) begin
          check((n.dir ? d_prdata : prdata) & n.msk, n.exp, "read data");
          check({31'h0, (n.dir ? d_pslverr : pslverr)}, {31'h0, n.err},
                "read error");
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // apb master
  // ----------------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
                    input logic err, output logic [31:0] r);
    notes.push_back('{e, m, err, 1'b0});
    apb(1'b0, a, 32'h0000_0000, r);
  endtask

  task automatic rc(input logic [31:0] e, input logic [31:0] m);
    logic [31:0] r;
    rd(`SMD_OFF_STATUS, e, m, 1'b0, r);
  endtask

  task automatic rdd(input logic [31:0] e);
    logic [31:0] r;
    notes.push_back('{e, 32'h1F, 1'b0, 1'b1});
    apb(1'b0, `SMD_OFF_STATUS, 32'h0000_0000, r);
  endtask

  task automatic poll(input int b, input logic v);
    logic [31:0] r;
    for (int i = 0; i < 200; i++) begin
      rd(`SMD_OFF_STATUS, 32'h0, 32'h0, 1'b0, r);
      if (r[b] === v) return;
    end
    check(32'h0, 32'h1, "status poll");
  endtask

  task automatic rx_pulse(input logic [25:0] a, b);
    rxlen_value <= a;
    pkt_len     <= b;
    rxlen_valid <= 1'b1;
    @(posedge pclk);
    rxlen_valid <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] r, tv;
    logic [25:0] lv;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {zero_len_desc, rxlen_valid, wr_err, pkt_too_long, slow} = '0;
    {rxlen_value, pkt_len} = '0;
    void'($urandom(88487));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(32'h09, 32'h1F);
    wr(`SMD_OFF_STATUS, 32'hFFFF_FFFF);
    rc(32'h09, 32'h1F);
    rd(8'h4C, 32'h0, 32'hFFFF_FFFF, 1'b1, r);
    tv = $urandom;
    wr(`SMD_OFF_TAIL, tv);
    repeat (3) @(posedge pclk);
    check(tail_ptr, tv, "tail stored");
    check(32'(starts), 32'h0, "halted tail start");
    wr(`SMD_OFF_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    rc(32'h08, 32'h1D);
    wr(`SMD_OFF_TAIL, $urandom);
    poll(`SMD_ST_IDLE, 1'b1);
    rc(32'h0A, 32'h1F);
    check(32'(starts), 32'h1, "running tail start");
    slow <= 1'b1;
    wr(`SMD_OFF_TAIL, $urandom);
    rc(32'h08, 32'h1F);
    wr(`SMD_OFF_CTRL, 32'h0);
    rc(32'h08, 32'h1F);
    poll(`SMD_ST_HALTED, 1'b1);
    check({31'h0, dm_busy}, 32'h0, "halted while busy");
    rc(32'h09, 32'h1F);
    wr(`SMD_OFF_TAIL, $urandom);
    repeat (3) @(posedge pclk);
    check(32'(starts), 32'h2, "halted tail start");
    wr(`SMD_OFF_IRQ_MASK, 32'h0);
    wr(`SMD_OFF_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    zero_len_desc <= 1'b1;
    @(posedge pclk);
    zero_len_desc <= 1'b0;
    @(posedge pclk);
    check({31'h0, run_bit}, 32'h0, "run after error");
    poll(`SMD_ST_HALTED, 1'b1);
    rc(32'h19, 32'h1F);
    check({31'h0, irq}, 32'h0, "masked irq");
    rd(`SMD_OFF_IRQ_STAT, 32'h4, 32'h4, 1'b0, r);
    wr(`SMD_OFF_IRQ_MASK, 32'h7);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h1, "unmasked irq");
    wr(`SMD_OFF_IRQ_STAT, 32'h7);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0, "cleared irq");
    rd(`SMD_OFF_IRQ_STAT, 32'h0, 32'h7, 1'b0, r);
    wr(`SMD_OFF_CTRL, 32'h1);
    repeat (10) @(posedge pclk);
    rc(32'h10, 32'h10);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(32'h09, 32'h1F);
    lv = 26'($urandom);
    wr(`SMD_OFF_CTRL, 32'h3);
    repeat (3) @(posedge pclk);
    rx_pulse(lv, lv);
    rc(32'h00, 32'h11);
    rx_pulse(lv ^ 26'h000_0001, lv);
    poll(`SMD_ST_HALTED, 1'b1);
    rc(32'h19, 32'h1F);
    rdd(32'h00);
    wr(`SMD_OFF_LEN, {6'h00, lv});
    repeat (30) @(posedge pclk);
    check(32'(dstarts), 32'h1, "direct length start");
    check({6'h00, d_xfer_len}, {6'h00, lv}, "direct length");
    check({6'h00, xfer_len}, {6'h00, lv}, "length stored");
    rdd(32'h02);
    wr_err <= 1'b1;
    @(posedge pclk);
    wr_err <= 1'b0;
    repeat (4) @(posedge pclk);
    rdd(32'h11);
    wr(`SMD_OFF_LEN, {6'h00, ~lv});
    repeat (3) @(posedge pclk);
    check(32'(dstarts), 32'h1, "halted length start");
    check(32'(starts), 32'h2, "desc build length start");
    wr(`SMD_OFF_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    pkt_too_long <= 1'b1;
    @(posedge pclk);
    pkt_too_long <= 1'b0;
    @(posedge pclk);
    check({31'h0, d_run}, 32'h0, "run after oversize");
    close_out();
  end
endmodule
